// ### dsbpwm_map.vh
// Purpose: Register map, field positions, reset values and divider counts
//          for the dual six-bit pulse width modulator.
// Assumes: Included by the block's single design file.
// Notes:   Definitions only.
`ifndef DSBPWM_MAP_VH
`define DSBPWM_MAP_VH

// ==========================================================
// Register byte addresses
`define DSBPWM_ADDR_W 8
`define DSBPWM_OFF_CTRL_A 8'h00
`define DSBPWM_OFF_CTRL_B 8'h04
`define DSBPWM_OFF_DUTY_A 8'h08
`define DSBPWM_OFF_DUTY_B 8'h0C
`define DSBPWM_OFF_STATUS 8'h10

// ==========================================================
// Register decode codes
`define DSBPWM_SEL_NONE 3'h0
`define DSBPWM_SEL_CTRL_A 3'h1
`define DSBPWM_SEL_CTRL_B 3'h2
`define DSBPWM_SEL_DUTY_A 3'h3
`define DSBPWM_SEL_DUTY_B 3'h4
`define DSBPWM_SEL_STATUS 3'h5

// ==========================================================
// Rate control fields
`define DSBPWM_COARSE_LSB 0
`define DSBPWM_COARSE_MSB 1
`define DSBPWM_FINE_LSB 2
`define DSBPWM_FINE_MSB 5
`define DSBPWM_CTRL_MASK 8'h3F
`define DSBPWM_CTRL_RESET 8'h00

// ==========================================================
// Duty fields
`define DSBPWM_DUTY_LSB 0
`define DSBPWM_DUTY_MSB 5
`define DSBPWM_POL_BIT 7
`define DSBPWM_DUTY_MASK 8'hBF

// ==========================================================
// Coarse divide terminal counts (divide minus one)
`define DSBPWM_COARSE_OFF 2'h0
`define DSBPWM_COARSE_DIV1 2'h1
`define DSBPWM_COARSE_DIV8 2'h2
`define DSBPWM_COARSE_DIV16 2'h3
`define DSBPWM_LIM_DIV1 4'h0
`define DSBPWM_LIM_DIV8 4'h7
`define DSBPWM_LIM_DIV16 4'hF
`define DSBPWM_CNT_LAST 6'h3F

// ==========================================================
// AXI responses
`define DSBPWM_RESP_OKAY 2'h0
`define DSBPWM_RESP_SLVERR 2'h2

`endif

// ### dsbpwm_top.v
// Purpose: Two six-bit pulse width modulator channels behind an AXI4-Lite
//          register slave.
// Assumes: aclk is the internal bus clock; stop_mode is asynchronous.
// Notes:   Duty and polarity bits have no reset on purpose.
//
// Summary of operation
// - Two channels, six-bit counter wrapping at 64
// - Prescalers run from the bus clock
// - Coarse field: off, divide 1, 8, 16
// - Fine field divides by value plus one
// - Period equals 64 scaled counter clocks
// - Duty zero, polarity low: output high
// - Polarity one active high, zero active low
// - Enabled: duty loads at period end
// - Disabled: duty write loads immediately
// - Control writes act immediately
// - Duty read returns active value
// - Coarse zero stops prescaler and counter
// - Channel owns pin while coarse nonzero
// - Channel B identical to A
// - Reset clears coarse, outputs low, keeps duty
// - Stop mode freezes waveform where it stands
// - Wait mode changes nothing

`timescale 1ns/100ps
`include "dsbpwm_map.vh"

module dsbpwm_top (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire stop_mode,
   input wire port_a_data,
   input wire port_b_data,
   output wire chan_a_pin,
   output wire chan_b_pin,
   output wire chan_a_pin_own,
   output wire chan_b_pin_own
);

   // ==========================================================
   // Decode shared by the read and write paths
   function [2:0] dsbpwm_decode;
      input [7:0] addr;
      begin
         if (addr == `DSBPWM_OFF_CTRL_A) begin
            dsbpwm_decode = `DSBPWM_SEL_CTRL_A;
         end else if (addr == `DSBPWM_OFF_CTRL_B) begin
            dsbpwm_decode = `DSBPWM_SEL_CTRL_B;
         end else if (addr == `DSBPWM_OFF_DUTY_A) begin
            dsbpwm_decode = `DSBPWM_SEL_DUTY_A;
         end else if (addr == `DSBPWM_OFF_DUTY_B) begin
            dsbpwm_decode = `DSBPWM_SEL_DUTY_B;
         end else if (addr == `DSBPWM_OFF_STATUS) begin
            dsbpwm_decode = `DSBPWM_SEL_STATUS;
         end else begin
            dsbpwm_decode = `DSBPWM_SEL_NONE;
         end
      end
   endfunction

   // Coarse terminal count; divide by 1, 8 or 16
   function [3:0] dsbpwm_coarse_lim;
      input [1:0] sel;
      begin
         case (sel)
            `DSBPWM_COARSE_DIV1: dsbpwm_coarse_lim = `DSBPWM_LIM_DIV1;
            `DSBPWM_COARSE_DIV8: dsbpwm_coarse_lim = `DSBPWM_LIM_DIV8;
            default: dsbpwm_coarse_lim = `DSBPWM_LIM_DIV16;
         endcase
      end
   endfunction

   // Limit reached; greater-or-equal so a smaller limit written mid-count
   // acts at once instead of letting the count run up to wraparound
   function dsbpwm_reached;
      input [3:0] count;
      input [3:0] limit;
      begin
         dsbpwm_reached = (count >= limit);
      end
   endfunction

   // ==========================================================
   // Stop mode synchroniser
   reg stop_meta;
   reg stop_sync;

   always @(posedge aclk) begin
      if (!aresetn) begin
         stop_meta <= 1'b0;
         stop_sync <= 1'b0;
      end else begin
         stop_meta <= stop_mode;
         stop_sync <= stop_meta;
      end
   end

   // ==========================================================
   // AXI4-Lite write path
   reg awready;
   reg wready;
   reg bvalid;
   reg [1:0] bresp;
   reg aw_held;
   reg w_held;
   reg [7:0] aw_addr;
   reg [7:0] w_data;
   reg w_lane0;
   wire do_write;
   wire [2:0] wr_sel;
   wire [1:0] wr_ctrl;
   wire [1:0] wr_duty;

   // A write completes once address and data are both captured
   assign do_write = aw_held && w_held && !bvalid;
   assign wr_sel = dsbpwm_decode(aw_addr);
   assign wr_ctrl[0] = do_write && w_lane0 && (wr_sel == `DSBPWM_SEL_CTRL_A);
   assign wr_ctrl[1] = do_write && w_lane0 && (wr_sel == `DSBPWM_SEL_CTRL_B);
   assign wr_duty[0] = do_write && w_lane0 && (wr_sel == `DSBPWM_SEL_DUTY_A);
   assign wr_duty[1] = do_write && w_lane0 && (wr_sel == `DSBPWM_SEL_DUTY_B);

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `DSBPWM_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 8'h00;
         w_lane0 <= 1'b0;
      end else begin
         // Ready is offered every other idle cycle; the master holds valid meanwhile
         awready <= !aw_held && !awready && !bvalid;
         wready <= !w_held && !wready && !bvalid;
         if (s_axi_awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            awready <= 1'b0;
         end
         if (s_axi_wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
            wready <= 1'b0;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            if ((wr_sel == `DSBPWM_SEL_NONE) || (wr_sel == `DSBPWM_SEL_STATUS)) begin
               bresp <= `DSBPWM_RESP_SLVERR;
            end else begin
               bresp <= `DSBPWM_RESP_OKAY;
            end
         end else if (bvalid && s_axi_bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Channels
   wire [15:0] ctrl_flat;
   wire [15:0] duty_flat;
   wire [11:0] cnt_flat;
   wire [1:0] pend_flat;
   wire [1:0] pin_flat;
   wire [1:0] own_flat;
   wire [1:0] port_data;

   assign port_data = {port_b_data, port_a_data};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         reg [7:0] ctrl;
         reg [7:0] duty_buf;
         reg [7:0] duty_act;
         reg pend;
         reg [3:0] coarse_cnt;
         reg [3:0] fine_cnt;
         reg [5:0] cnt;
         reg pin;
         reg own;
         wire [1:0] coarse;
         wire [3:0] fine;
         wire enabled;
         wire run;
         wire coarse_tick;
         wire cnt_tick;
         wire period_end;
         wire active;
         wire wave;

         // ==========================================================
         // Rate decode and tick generation
         assign coarse = ctrl[`DSBPWM_COARSE_MSB:`DSBPWM_COARSE_LSB];
         assign fine = ctrl[`DSBPWM_FINE_MSB:`DSBPWM_FINE_LSB];
         assign enabled = (coarse != `DSBPWM_COARSE_OFF);
         // No separate wait input: the channel runs the same in wait mode
         assign run = enabled && !stop_sync;
         assign coarse_tick = run &&
                              dsbpwm_reached(coarse_cnt, dsbpwm_coarse_lim(coarse));
         assign cnt_tick = coarse_tick && dsbpwm_reached(fine_cnt, fine);
         assign period_end = cnt_tick && (cnt == `DSBPWM_CNT_LAST);
         assign active = (cnt < duty_act[`DSBPWM_DUTY_MSB:`DSBPWM_DUTY_LSB]);
         // Polarity low with duty zero leaves the line high
         assign wave = duty_act[`DSBPWM_POL_BIT] ? active : !active;

         // ==========================================================
         // Rate control register
         // Control takes effect on the next clock, even mid-period
         always @(posedge aclk) begin
            if (!aresetn) begin
               ctrl <= `DSBPWM_CTRL_RESET;
            end else if (wr_ctrl[ch]) begin
               ctrl <= w_data & `DSBPWM_CTRL_MASK;
            end
         end

         // ==========================================================
         // Duty registers
         // Duty holds its contents through reset, so it has no reset term
         always @(posedge aclk) begin
            if (wr_duty[ch]) begin
               duty_buf <= w_data & `DSBPWM_DUTY_MASK;
            end
            if (wr_duty[ch] && !enabled) begin
               duty_act <= w_data & `DSBPWM_DUTY_MASK;
            end else if (period_end && pend) begin
               duty_act <= duty_buf;
            end
         end

         always @(posedge aclk) begin
            if (!aresetn) begin
               pend <= 1'b0;
            end else if (wr_duty[ch]) begin
               pend <= enabled;
            end else if (period_end || !enabled) begin
               pend <= 1'b0;
            end
         end

         // ==========================================================
         // Prescaler and counter
         // Counters hold at zero while off so nothing toggles
         always @(posedge aclk) begin
            if (!aresetn || !enabled) begin
               coarse_cnt <= 4'h0;
               fine_cnt <= 4'h0;
               cnt <= 6'h00;
            end else if (run) begin
               if (coarse_tick) begin
                  coarse_cnt <= 4'h0;
                  if (cnt_tick) begin
                     fine_cnt <= 4'h0;
                     cnt <= cnt + 6'h01;
                  end else begin
                     fine_cnt <= fine_cnt + 4'h1;
                  end
               end else begin
                  coarse_cnt <= coarse_cnt + 4'h1;
               end
            end
         end

         // ==========================================================
         // Pin drive
         // Pin mux; in stop mode the counter freezes, so the level holds
         always @(posedge aclk) begin
            if (!aresetn) begin
               pin <= 1'b0;
               own <= 1'b0;
            end else begin
               own <= enabled;
               pin <= enabled ? wave : port_data[ch];
            end
         end

         assign ctrl_flat[ch*8 +: 8] = ctrl;
         assign duty_flat[ch*8 +: 8] = duty_act;
         assign cnt_flat[ch*6 +: 6] = cnt;
         assign pend_flat[ch] = pend;
         assign pin_flat[ch] = pin;
         assign own_flat[ch] = own;
      end
   endgenerate

   assign chan_a_pin = pin_flat[0];
   assign chan_b_pin = pin_flat[1];
   assign chan_a_pin_own = own_flat[0];
   assign chan_b_pin_own = own_flat[1];

   // ==========================================================
   // AXI4-Lite read path
   reg arready;
   reg rvalid;
   reg [31:0] rdata;
   reg [1:0] rresp;
   reg [31:0] next_rdata;
   reg [1:0] next_rresp;

   // Duty is undefined until first written; software loads it before enabling
   always @* begin
      next_rdata = 32'h00000000;
      next_rresp = `DSBPWM_RESP_OKAY;
      case (dsbpwm_decode({s_axi_araddr[7:2], 2'b00}))
         `DSBPWM_SEL_CTRL_A: next_rdata[7:0] = ctrl_flat[7:0];
         `DSBPWM_SEL_CTRL_B: next_rdata[7:0] = ctrl_flat[15:8];
         `DSBPWM_SEL_DUTY_A: next_rdata[7:0] = duty_flat[7:0];
         `DSBPWM_SEL_DUTY_B: next_rdata[7:0] = duty_flat[15:8];
         `DSBPWM_SEL_STATUS: next_rdata[15:0] = {pend_flat, cnt_flat[11:6], 2'b00,
                                                 cnt_flat[5:0]};
         default: next_rresp = `DSBPWM_RESP_SLVERR;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `DSBPWM_RESP_OKAY;
      end else begin
         // One read at a time: no new address while the answer stands
         arready <= !rvalid && !arready;
         if (s_axi_arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
         end else if (rvalid && s_axi_rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready;
   assign s_axi_wready = wready;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = arready;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;

endmodule // dsbpwm_top

// ### dsbpwm_checker.sv
// Purpose: Port-level assertions for the dual six-bit PWM block.
// Assumes: Sees only the top module's ports; one clock domain.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/100ps
module dsbpwm_checker (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire [31:0] s_axi_rdata,
   input wire stop_mode,
   input wire port_a_data,
   input wire port_b_data,
   input wire chan_a_pin,
   input wire chan_b_pin,
   input wire chan_a_pin_own,
   input wire chan_b_pin_own
);
// ==========================================================
// Sequences
default clocking @(posedge aclk);
endclocking
default disable iff (!aresetn);
sequence s_read_taken;
   s_axi_arvalid && s_axi_arready;
endsequence
// Five cycles cover the two-stage sync plus the registered pin
sequence s_stopped_a;
   (stop_mode && chan_a_pin_own)[*5];
endsequence
// ==========================================================
// Assertions
a_reset_quiet: assert property (disable iff (1'h0)
   !aresetn |=> !chan_a_pin && !chan_b_pin && !chan_a_pin_own && !chan_b_pin_own)
   else $error("pins not quiet after reset");
a_gpio_pass_a: assert property (
   !chan_a_pin_own && !$past(chan_a_pin_own) && $past(aresetn) |-> chan_a_pin == $past(port_a_data))
   else $error("pin a not following port data");
a_gpio_pass_b: assert property (
   !chan_b_pin_own && !$past(chan_b_pin_own) && $past(aresetn) |-> chan_b_pin == $past(port_b_data))
   else $error("pin b not following port data");
a_stop_freeze: assert property (s_stopped_a |-> $stable(chan_a_pin))
   else $error("pin a moved in stop mode");
a_own_on_write: assert property ($rose(chan_a_pin_own) |-> s_axi_bvalid || $past(s_axi_bvalid))
   else $error("pin a taken without a write");
a_own_release: assert property (
   $fell(chan_a_pin_own) && $past(aresetn) |-> s_axi_bvalid || $past(s_axi_bvalid))
   else $error("pin a released without a write");
a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
   else $error("read not answered next cycle");
a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
   else $error("upper read bits not zero");
endmodule // dsbpwm_checker
bind dsbpwm_top dsbpwm_checker dsbpwm_checker_inst (.*);

// ### tb_dual_six_bit_pwm.sv
// Purpose: Self-checking bench for the dual six-bit PWM block.
// Assumes: 100 MHz aclk; AXI4-Lite master tasks below.
// Notes:   Waveforms are judged by counting high samples in a window.
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_dual_six_bit_pwm;
// ==========================================================
// Signals
logic aclk = 1'h0;
logic aresetn = 1'h0;
logic [7:0] s_axi_awaddr = 8'h00;
logic [7:0] s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h0;
logic [3:0] s_axi_wstrb = 4'hF;
logic [2:0] s_axi_awprot = 3'h0;
logic [2:0] s_axi_arprot = 3'h0;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, stop_mode = 1'h0;
logic port_a_data = 1'h0, port_b_data = 1'h0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire chan_a_pin, chan_b_pin, chan_a_pin_own, chan_b_pin_own;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
int error_cnt = 0, samples_checked = 0, cyc = 0;
logic [7:0] dt [5] = '{8'h90, 8'hBF, 8'h80, 8'h00, 8'h10};
int hc [5] = '{32, 126, 0, 128, 96};
logic [7:0] pc [5] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h3D};
int pp [5] = '{64, 512, 1024, 128, 1024};
logic held;

dsbpwm_top dsbpwm_top_inst (.*);

always #5 aclk = ~aclk;
// Port data toggles so the idle pins have something to follow
always @(posedge aclk) begin
   port_a_data <= ~port_a_data;
   port_b_data <= port_a_data;
   cyc++;
   // Run needs about 11k cycles; ceiling leaves ample margin
   if (cyc == 40000) begin
      error_cnt++;
      summarize();
   end
end
// ==========================================================
// Tasks
task summarize;
   if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
   else
      $display("Checks failed");
   $finish;
endtask
task automatic wr(input [7:0] a, input [7:0] d, input [1:0] er = 2'h0);
   @(posedge aclk);
   s_axi_awaddr <= a;
   s_axi_wdata <= {24'h0, d};
   s_axi_awvalid <= 1'h1;
   s_axi_wvalid <= 1'h1;
   s_axi_bready <= 1'h1;
   forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
         s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
         s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) begin
         `CHK(s_axi_bresp, er)
         s_axi_bready <= 1'h0;
         break;
      end
   end
endtask
task automatic rd(input [7:0] a, input [31:0] e, input [1:0] er = 2'h0,
                  input [31:0] m = 32'hFFFFFFFF);
   @(posedge aclk);
   s_axi_araddr <= a;
   s_axi_arvalid <= 1'h1;
   s_axi_rready <= 1'h1;
   forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
         s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) begin
         `CHK(s_axi_rdata & m, e)
         `CHK(s_axi_rresp, er)
         s_axi_rready <= 1'h0;
         break;
      end
   end
endtask
task automatic cnt(input int ch, input int n, input int e);
   int h;
   h = 0;
   repeat (n) begin
      @(negedge aclk);
      h += ((ch ? chan_b_pin : chan_a_pin) === 1'h1);
   end
   `CHK(h, e)
endtask
task automatic rst;
   @(posedge aclk);
   aresetn <= 1'h0;
   repeat (20) @(posedge aclk);
   aresetn <= 1'h1;
   @(negedge aclk);
   `CHK({chan_a_pin, chan_b_pin, chan_a_pin_own, chan_b_pin_own}, 4'h0)
   rd(8'h00, 32'h0);
   rd(8'h04, 32'h0);
endtask
// ==========================================================
// Sequence of tests
initial begin
   rst();
   for (int ch = 0; ch < 2; ch++) begin
      wr(8'(8 + ch * 4), 8'h90);
      rd(8'(8 + ch * 4), 32'h90);
      wr(8'(ch * 4), 8'h01);
      @(negedge aclk);
      `CHK(ch ? chan_b_pin_own : chan_a_pin_own, 1'h1)
      for (int i = 0; i < 5; i++) begin
         wr(8'(8 + ch * 4), dt[i]);
         repeat (70) @(posedge aclk);
         cnt(ch, 128, hc[i]);
      end
   end
   // Restart from count zero so the slow period end lies far past the read-back
   wr(8'h00, 8'h00);
   wr(8'h00, 8'h3F);
   wr(8'h08, 8'hA0);
   rd(8'h08, 32'h10);
   rd(8'h10, 32'h4000, 2'h0, 32'h4000);
   wr(8'h00, 8'h01);
   repeat (70) @(posedge aclk);
   rd(8'h08, 32'hA0);
   for (int i = 0; i < 5; i++) begin
      wr(8'h00, pc[i]);
      repeat (pp[i]) @(posedge aclk);
      cnt(0, 2 * pp[i], pp[i]);
   end
   wr(8'h00, 8'h01);
   @(posedge aclk);
   stop_mode <= 1'h1;
   repeat (8) @(negedge aclk);
   held = chan_a_pin;
   repeat (300) @(negedge aclk);
   `CHK(chan_a_pin, held)
   @(posedge aclk);
   stop_mode <= 1'h0;
   wr(8'h00, 8'h00);
   @(negedge aclk);
   `CHK(chan_a_pin_own, 1'h0)
   rd(8'h10, 32'h0, 2'h0, 32'h3F);
   rd(8'h14, 32'h0, 2'h2);
   wr(8'h10, 8'h01, 2'h2);
   wr(8'h0C, 8'h9A);
   repeat (70) @(posedge aclk);
   rst();
   rd(8'h0C, 32'h9A);
   summarize();
end
endmodule // tb_dual_six_bit_pwm
